// ---- design/osaf_consts.svh ----
// timing and format constants of the oversampling average filter
`ifndef OSAF_CONSTS_SVH
`define OSAF_CONSTS_SVH
`define OSAF_NCH           8
`define OSAF_SAMPLE_W      14
`define OSAF_ACC_W         20
`define OSAF_LOG2_W        3
`define OSAF_CNT_W         6
`define OSAF_CLK_NS        5
`define OSAF_SAMPLE_PER_NS 5000
`define OSAF_SAMPLE_PER_CYC (`OSAF_SAMPLE_PER_NS / `OSAF_CLK_NS)
`define OSAF_PER_W         10
`define OSAF_RATIO_NONE    3'h0
`define OSAF_RATIO_64      3'h6
`define OSAF_RATIO_BAD     3'h7
`endif

// ---- design/osaf_pkg.sv ----
// types of the oversampling average filter
`include "osaf_consts.svh"
package osaf_pkg;
   typedef logic signed [`OSAF_SAMPLE_W-1:0] osaf_sample_t;
   typedef logic signed [`OSAF_ACC_W-1:0]    osaf_acc_t;
   typedef struct packed {
      osaf_sample_t [`OSAF_NCH-1:0] ch;
   } osaf_frame_t;
   typedef enum logic [3:0] {
      OSAF_IDLE = 4'h1,
      OSAF_CONV = 4'h2,
      OSAF_GAP  = 4'h4,
      OSAF_OUT  = 4'h8
   } osaf_state_t;
endpackage : osaf_pkg

// ---- design/osaf_filter.sv ----
// oversampling averaging filter in front of the eight converter channels
//
// Overview of operation
// - ratio_select 000 none, 001..110 averages 2..64
// - throughput falls with ratio; host respects it
// - first sample on trigger rising edge
// - remaining samples by internal strobes
// - average samples of each channel
// - one 14-bit word per channel per set
// - results are two's complement
`timescale 1ns/1ps
`default_nettype none
`include "osaf_consts.svh"
module osaf_filter (
   input  wire logic                          clk,
   input  wire logic                          rst,
   input  wire logic                          sample_trigger_a,
   input  wire logic                          sample_trigger_b,
   input  wire logic [2:0]                    ratio_select,
   output logic                               conv_start,
   input  wire logic                          conv_done,
   input  wire osaf_pkg::osaf_frame_t         conv_data,
   output logic                               busy,
   output logic                               out_valid,
   input  wire logic                          out_ready,
   output osaf_pkg::osaf_frame_t              out_data
);
   // ==========================================================
   // decoding
   // 111 is forbidden; falling back to single samples keeps output sane
   function automatic logic [`OSAF_LOG2_W-1:0] ratio_log2(input logic [2:0] code);
      if (code == `OSAF_RATIO_BAD) begin
         return `OSAF_RATIO_NONE;
      end
      return code;
   endfunction : ratio_log2

   // ==========================================================
   // pin synchronisers
   logic [2:0] sync_a_r;
   logic [2:0] sync_b_r;
   logic [2:0] sync_os0_r;
   logic [2:0] sync_os1_r;
   logic [2:0] sync_os2_r;
   logic       trig_lvl_r;
   logic       trig_lvl_nxt;
   logic [2:0] ratio_r;
   logic [2:0] ratio_nxt;

   always_comb begin
      trig_lvl_nxt = trig_lvl_r;
      ratio_nxt    = ratio_r;
      // triggers treated as one signal, both must agree high
      if (sync_a_r[1] == sync_a_r[2] && sync_b_r[1] == sync_b_r[2]) begin
         trig_lvl_nxt = sync_a_r[2] & sync_b_r[2];
      end
      if (sync_os0_r[1] == sync_os0_r[2]) begin
         ratio_nxt[0] = sync_os0_r[2];
      end
      if (sync_os1_r[1] == sync_os1_r[2]) begin
         ratio_nxt[1] = sync_os1_r[2];
      end
      if (sync_os2_r[1] == sync_os2_r[2]) begin
         ratio_nxt[2] = sync_os2_r[2];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sync_a_r   <= 3'h0;
         sync_b_r   <= 3'h0;
         sync_os0_r <= 3'h0;
         sync_os1_r <= 3'h0;
         sync_os2_r <= 3'h0;
         trig_lvl_r <= 1'h0;
         ratio_r    <= 3'h0;
      end else begin
         sync_a_r   <= {sync_a_r[1:0], sample_trigger_a};
         sync_b_r   <= {sync_b_r[1:0], sample_trigger_b};
         sync_os0_r <= {sync_os0_r[1:0], ratio_select[0]};
         sync_os1_r <= {sync_os1_r[1:0], ratio_select[1]};
         sync_os2_r <= {sync_os2_r[1:0], ratio_select[2]};
         trig_lvl_r <= trig_lvl_nxt;
         ratio_r    <= ratio_nxt;
      end
   end

   // ==========================================================
   // sequencer and accumulators
   osaf_pkg::osaf_state_t                  state_r;
   osaf_pkg::osaf_state_t                  state_nxt;
   logic                                   trig_prev_r;
   logic [`OSAF_LOG2_W-1:0]                lg_r;
   logic [`OSAF_LOG2_W-1:0]                lg_nxt;
   logic [`OSAF_CNT_W-1:0]                 cnt_r;
   logic [`OSAF_CNT_W-1:0]                 cnt_nxt;
   logic [`OSAF_PER_W-1:0]                 per_r;
   logic [`OSAF_PER_W-1:0]                 per_nxt;
   logic                                   conv_start_r;
   logic                                   conv_start_nxt;
   logic                                   busy_r;
   logic                                   busy_nxt;
   osaf_pkg::osaf_acc_t [`OSAF_NCH-1:0]    acc_r;
   osaf_pkg::osaf_acc_t [`OSAF_NCH-1:0]    acc_nxt;
   osaf_pkg::osaf_frame_t                  avg;
   logic                                   in_push;
   logic                                   in_ready;
   logic [`OSAF_CNT_W-1:0]                 last_cnt;

   assign last_cnt = `OSAF_CNT_W'((1 << lg_r) - 1);

   // decimation: sum over N shifted right by log2(N) fits 14 bits again
   for (genvar c = 0; c < `OSAF_NCH; c++) begin : g_avg
      osaf_pkg::osaf_acc_t shifted;
      assign shifted   = acc_r[c] >>> lg_r;
      assign avg.ch[c] = shifted[`OSAF_SAMPLE_W-1:0];
   end

   always_comb begin
      state_nxt      = state_r;
      lg_nxt         = lg_r;
      cnt_nxt        = cnt_r;
      acc_nxt        = acc_r;
      conv_start_nxt = 1'h0;
      in_push        = 1'h0;
      per_nxt        = (per_r == `OSAF_PER_W'(`OSAF_SAMPLE_PER_CYC - 1)) ? per_r : per_r + `OSAF_PER_W'(1);
      unique case (state_r)
         osaf_pkg::OSAF_IDLE: begin
            if (trig_lvl_r && !trig_prev_r) begin
               conv_start_nxt = 1'h1;
               lg_nxt         = ratio_log2(ratio_r);
               cnt_nxt        = '0;
               acc_nxt        = '0;
               per_nxt        = '0;
               state_nxt      = osaf_pkg::OSAF_CONV;
            end
         end
         osaf_pkg::OSAF_CONV: begin
            if (conv_done) begin
               for (int c = 0; c < `OSAF_NCH; c++) begin
                  acc_nxt[c] = acc_r[c] + `OSAF_ACC_W'(conv_data.ch[c]);
               end
               cnt_nxt   = cnt_r + `OSAF_CNT_W'(1);
               state_nxt = (cnt_r == last_cnt) ? osaf_pkg::OSAF_OUT : osaf_pkg::OSAF_GAP;
            end
         end
         osaf_pkg::OSAF_GAP: begin
            // spacing strobes one sample period apart bounds the set rate
            if (per_r == `OSAF_PER_W'(`OSAF_SAMPLE_PER_CYC - 1)) begin
               conv_start_nxt = 1'h1;
               per_nxt        = '0;
               state_nxt      = osaf_pkg::OSAF_CONV;
            end
         end
         osaf_pkg::OSAF_OUT: begin
            if (in_ready) begin
               in_push   = 1'h1;
               state_nxt = osaf_pkg::OSAF_IDLE;
            end
         end
      endcase
      busy_nxt = (state_nxt != osaf_pkg::OSAF_IDLE);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r      <= osaf_pkg::OSAF_IDLE;
         trig_prev_r  <= 1'h0;
         lg_r         <= '0;
         cnt_r        <= '0;
         per_r        <= '0;
         acc_r        <= '0;
         conv_start_r <= 1'h0;
         busy_r       <= 1'h0;
      end else begin
         state_r      <= state_nxt;
         trig_prev_r  <= trig_lvl_r;
         lg_r         <= lg_nxt;
         cnt_r        <= cnt_nxt;
         per_r        <= per_nxt;
         acc_r        <= acc_nxt;
         conv_start_r <= conv_start_nxt;
         busy_r       <= busy_nxt;
      end
   end

   // ==========================================================
   // two-entry output buffer
   logic                  out_valid_r;
   logic                  out_valid_nxt;
   osaf_pkg::osaf_frame_t out_data_r;
   osaf_pkg::osaf_frame_t out_data_nxt;
   logic                  skid_valid_r;
   logic                  skid_valid_nxt;
   osaf_pkg::osaf_frame_t skid_data_r;
   osaf_pkg::osaf_frame_t skid_data_nxt;

   // the set stalls in OUT while the skid slot is taken
   assign in_ready = !skid_valid_r;

   always_comb begin
      out_valid_nxt  = out_valid_r;
      out_data_nxt   = out_data_r;
      skid_valid_nxt = skid_valid_r;
      skid_data_nxt  = skid_data_r;
      if (out_ready || !out_valid_r) begin
         if (skid_valid_r) begin
            out_valid_nxt  = 1'h1;
            out_data_nxt   = skid_data_r;
            skid_valid_nxt = 1'h0;
         end else begin
            out_valid_nxt = in_push;
            if (in_push) begin
               out_data_nxt = avg;
            end
         end
      end else if (in_push) begin
         skid_valid_nxt = 1'h1;
         skid_data_nxt  = avg;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         out_valid_r  <= 1'h0;
         out_data_r   <= '0;
         skid_valid_r <= 1'h0;
         skid_data_r  <= '0;
      end else begin
         out_valid_r  <= out_valid_nxt;
         out_data_r   <= out_data_nxt;
         skid_valid_r <= skid_valid_nxt;
         skid_data_r  <= skid_data_nxt;
      end
   end

   assign conv_start = conv_start_r;
   assign busy       = busy_r;
   assign out_valid  = out_valid_r;
   assign out_data   = out_data_r;
endmodule : osaf_filter
`default_nettype wire

// ---- tb/osaf_core_model.sv ----
// converter core model answering conv_start
`timescale 1ns/1ps
`default_nettype none
// ==========
// core model
module osaf_core_model #(parameter int LAT = 20) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             conv_start,
   output var  logic             conv_done,
   output var  osaf_pkg::osaf_frame_t conv_data
);
   int cnt;
   int k;
   always @(posedge clk) begin
      conv_done <= 1'b0;
      // stale word inverted so nothing relies on it
      if (conv_done) conv_data <= ~conv_data;
      if (rst) begin
         cnt <= 0;
         k <= 0;
         conv_data <= '0;
      end else if (conv_start) begin
         cnt <= LAT;
      end else if (cnt == 1) begin
         cnt <= 0;
         k <= k + 1;
         conv_done <= 1'b1;
         for (int c = 0; c < 8; c++) conv_data.ch[c] <= 14'(c * 2000 - 7000 + 3 * k);
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule : osaf_core_model
`default_nettype wire

// ---- tb/osaf_filter_asserts.sv ----
// assertions on the filter ports
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checks
module osaf_filter_chk (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       sample_trigger_a,
   input wire logic       sample_trigger_b,
   input wire logic [2:0] ratio_select,
   input wire logic       conv_start,
   input wire logic       conv_done,
   input wire osaf_pkg::osaf_frame_t conv_data,
   input wire logic       busy,
   input wire logic       out_valid,
   input wire logic       out_ready,
   input wire osaf_pkg::osaf_frame_t out_data
);
   localparam int TMIN = 2;
   localparam int TMAX = 10;
   logic [9:0] gap_r;
   logic [7:0] n_r;
   logic [2:0] ratio_r;
   logic       busy_q;
   logic [7:0] exp_n;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // counts strobes of one set and cycles between them
   always_ff @(posedge clk) begin
      busy_q <= busy;
      gap_r <= conv_start ? 10'h000 : (gap_r == 10'h3FF ? gap_r : gap_r + 10'h001);
      if (conv_start && !busy_q) ratio_r <= ratio_select;
      if (conv_start) n_r <= busy_q ? n_r + 8'h01 : 8'h01;
   end
   assign exp_n = (ratio_r == 3'h7) ? 8'h01 : 8'h01 << ratio_r;
   start_pulse_a: assert property (conv_start |=> !conv_start) else $error("long strobe");
   start_busy_a: assert property (conv_start |-> busy[*3]) else $error("busy not held");
   rise_first_a: assert property ($rose(busy) |-> conv_start) else $error("busy without strobe");
   trig_start_a: assert property ($rose(sample_trigger_a && sample_trigger_b) && !busy
      |-> ##[TMIN:TMAX] conv_start) else $error("trigger not taken");
   strobe_gap_a: assert property (conv_start && $past(busy) |-> gap_r == 10'h3E7) else $error("bad gap");
   set_count_a: assert property ($fell(busy) |-> n_r == exp_n) else $error("wrong sample count");
   busy_fall_a: assert property ($fell(busy) |-> ##[0:1] out_valid) else $error("no result");
   out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("result dropped");
   cover property (conv_start && $past(busy));
   cover property (out_valid && !out_ready ##1 out_valid);
   cover property ($fell(busy));
endmodule : osaf_filter_chk
bind osaf_filter osaf_filter_chk u_chk (.clk(clk), .rst(rst), .sample_trigger_a(sample_trigger_a),
   .sample_trigger_b(sample_trigger_b), .ratio_select(ratio_select), .conv_start(conv_start),
   .conv_done(conv_done), .conv_data(conv_data), .busy(busy), .out_valid(out_valid),
   .out_ready(out_ready), .out_data(out_data));
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench of the oversampling filter
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic trg = 1'b0;
   logic [2:0] ratio = 3'h0;
   logic out_ready = 1'b0;
   logic conv_start, conv_done, busy, out_valid;
   osaf_pkg::osaf_frame_t conv_data, out_data;
   int miscompares = 0;
   int samples_checked = 0;
   int cyc = 0;
   int kk = 0;
   int t0 = 0;
   int np = 1;
   int strobes = 0;
   int s0 = 0;
   always #2.5 clk = ~clk;
   osaf_filter dut (.clk(clk), .rst(rst), .sample_trigger_a(trg), .sample_trigger_b(trg),
      .ratio_select(ratio), .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data),
      .busy(busy), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
   osaf_core_model u_core (.clk(clk), .rst(rst), .conv_start(conv_start), .conv_done(conv_done),
      .conv_data(conv_data));
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   function automatic int nof(input logic [2:0] r);
      return (r == 3'h7) ? 1 : 1 << r;
   endfunction : nof
   task automatic start_set(input logic [2:0] r);
      ratio = r;
      trg = 1'b1;
      t0 = cyc;
      s0 = strobes;
      np = nof(r);
      for (int i = 0; i < 20 && busy !== 1'b1; i++) tick(1);
      chk({13'h0000, busy}, 14'h0001);
   endtask : start_set
   task automatic end_set;
      for (int i = 0; i < 70000 && busy !== 1'b0; i++) tick(1);
      chk({13'h0000, busy}, 14'h0000);
      chk(14'(strobes - s0), 14'(np));
      trg = 1'b0;
      while (cyc - t0 < np * 1000) tick(1);
   endtask : end_set
   task automatic take(input logic [2:0] r);
      osaf_pkg::osaf_acc_t s;
      for (int i = 0; i < 100 && out_valid !== 1'b1; i++) tick(1);
      chk({13'h0000, out_valid}, 14'h0001);
      for (int c = 0; c < 8; c++) begin
         s = '0;
         for (int j = 0; j < nof(r); j++) s += 20'(c * 2000 - 7000 + 3 * (kk + j));
         s = s >>> ((r == 3'h7) ? 3'h0 : r);
         chk(out_data.ch[c], s[13:0]);
      end
      kk += nof(r);
      out_ready = 1'b1;
      tick(1);
      out_ready = 1'b0;
      // one idle cycle so a following take never re-raises ready in the same step
      tick(1);
   endtask : take
   task automatic scn_single;
      // no averaging: plain code and the forbidden code
      start_set(3'h0);
      end_set();
      take(3'h0);
      start_set(3'h7);
      end_set();
      take(3'h7);
   endtask : scn_single
   task automatic scn_average;
      for (int r = 1; r < 7; r++) begin
         start_set(3'(r));
         end_set();
         take(3'(r));
      end
   endtask : scn_average
   task automatic scn_stall;
      // two results parked, the third set must stall
      start_set(3'h0);
      end_set();
      start_set(3'h1);
      end_set();
      start_set(3'h0);
      tick(3000);
      chk({13'h0000, busy}, 14'h0001);
      take(3'h0);
      end_set();
      take(3'h1);
      take(3'h0);
   endtask : scn_stall
   always @(posedge clk) begin
      cyc++;
      if (conv_start === 1'b1) strobes++;
      if (cyc == 150000) begin
         miscompares++;
         print_verdict();
      end
   end
   initial begin
      tick(20);
      rst = 1'b0;
      tick(2);
      scn_single();
      scn_average();
      scn_stall();
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
